//--- rtl/pcio_core.sv
// pin change detection, change interrupt masking and open-drain driver control
// Summary of operation
// - mask view readable, cleared at reset
// - mask changes only via enable/disable writes
// - a pin edge held for two clocks after the sync chain fills sets its change bit
// - detect on all pins, any ownership/direction
// - reading change status clears it; reset clears
// - change bit sticks until read
// - open-drain set write: ones enable open drain
// - open-drain clear write: ones restore push-pull
// - open-drain view readable, cleared at reset
// - enable write: ones enable change interrupt
// - disable write: ones disable, detection continues
`timescale 1ns/1ns
module pcio_core
   import pcio_pkg::*;
#(
   parameter int NPINS = PCIO_NPINS
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // classic wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pins and port unit
   input wire logic [NPINS-1:0] pin_in,
   input wire logic [NPINS-1:0] out_data,
   input wire logic [NPINS-1:0] drive_en,
   output logic [NPINS-1:0] pin_out,
   output logic [NPINS-1:0] pin_oe_n,
   // interrupt request
   output logic irq
);
   typedef struct packed {
      logic [NPINS-1:0] sync1;
      logic [NPINS-1:0] sync2;
      logic [NPINS-1:0] sync3;
      logic [NPINS-1:0] level;
      logic [1:0] fill;
      logic [NPINS-1:0] mask;
      logic [NPINS-1:0] change;
      logic [NPINS-1:0] odrain;
      logic ack;
      logic [31:0] rdata;
   } pcio_state_s;

   pcio_state_s st_q;
   pcio_state_s st_d;

   logic req;
   logic wr;
   logic rd;
   logic [31:0] wmask;
   logic [NPINS-1:0] wbits;
   logic [NPINS-1:0] stable;
   logic [NPINS-1:0] edge_seen;
   logic [NPINS-1:0] level_nxt;
   logic [NPINS-1:0] drv_on;
   logic primed;
   logic hit_ien;
   logic hit_idis;
   logic hit_imask;
   logic hit_change;
   logic hit_odset;
   logic hit_odclr;
   logic hit_odstat;
   logic wr_ien;
   logic wr_idis;
   logic wr_odset;
   logic wr_odclr;
   logic rd_change;

   // request taken in the first cycle of a strobe; ack comes one cycle later
   assign req = wb_cyc_i && wb_stb_i && !st_q.ack;
   // a write lands at the edge where the master samples ack high
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && st_q.ack;
   assign rd = req && !wb_we_i;

   // one strobe per register; an address outside the map matches none
   assign hit_ien = wb_adr_i == PCIO_OFS_IRQ_ENABLE_SET;
   assign hit_idis = wb_adr_i == PCIO_OFS_IRQ_ENABLE_CLEAR;
   assign hit_imask = wb_adr_i == PCIO_OFS_IRQ_MASK_STATUS;
   assign hit_change = wb_adr_i == PCIO_OFS_PIN_CHANGE_STATUS;
   assign hit_odset = wb_adr_i == PCIO_OFS_OPEN_DRAIN_SET;
   assign hit_odclr = wb_adr_i == PCIO_OFS_OPEN_DRAIN_CLEAR;
   assign hit_odstat = wb_adr_i == PCIO_OFS_OPEN_DRAIN_STATUS;
   assign wr_ien = wr && hit_ien;
   assign wr_idis = wr && hit_idis;
   assign wr_odset = wr && hit_odset;
   assign wr_odclr = wr && hit_odclr;
   assign rd_change = rd && hit_change;

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
      end
   end
   assign wbits = NPINS'(wb_dat_i & wmask);

   // a pin level counts only once the second and third stages agree
   // until the chain has filled after reset the level is only loaded, so a
   // line that idles high reports no change; only an edge before the first pin sample after reset is lost
   assign primed = st_q.fill == PCIO_SYNC_FILL;
   for (genvar p = 0; p < NPINS; p++) begin : g_pin_edge
      assign stable[p] = st_q.sync2[p] == st_q.sync3[p];
      assign edge_seen[p] = primed && stable[p] && (st_q.sync2[p] != st_q.level[p]);
      assign level_nxt[p] = (stable[p] || !primed) ? st_q.sync2[p] : st_q.level[p];
   end

   always_comb begin
      st_d = st_q;
      st_d.sync1 = pin_in;
      st_d.sync2 = st_q.sync1;
      st_d.sync3 = st_q.sync2;
      st_d.level = level_nxt;
      if (!primed) begin
         st_d.fill = st_q.fill + 2'h1;
      end
      st_d.ack = req;
      if (wr_ien) begin
         st_d.mask = st_q.mask | wbits;
      end
      if (wr_idis) begin
         st_d.mask = st_q.mask & ~wbits;
      end
      if (wr_odset) begin
         st_d.odrain = st_q.odrain | wbits;
      end
      if (wr_odclr) begin
         st_d.odrain = st_q.odrain & ~wbits;
      end
      // a read clears the status, but an edge in the same cycle survives
      if (rd_change) begin
         st_d.change = edge_seen;
      end else begin
         st_d.change = st_q.change | edge_seen;
      end
      st_d.rdata = 32'h0000_0000;
      if (rd) begin
         unique case (wb_adr_i)
            PCIO_OFS_IRQ_MASK_STATUS: st_d.rdata = 32'(st_q.mask);
            PCIO_OFS_PIN_CHANGE_STATUS: st_d.rdata = 32'(st_q.change);
            PCIO_OFS_OPEN_DRAIN_STATUS: st_d.rdata = 32'(st_q.odrain);
            default: st_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '0;
         st_q.mask <= NPINS'(PCIO_RST_MASK);
         st_q.change <= NPINS'(PCIO_RST_CHANGE);
         st_q.odrain <= NPINS'(PCIO_RST_OPEN_DRAIN);
      end else begin
         st_q <= st_d;
      end
   end

   assign wb_ack_o = st_q.ack;
   assign wb_dat_o = st_q.rdata;
   assign irq = |(st_q.change & st_q.mask);

   // push-pull drives both levels; open drain drives only a zero and leaves
   // a one to the pull-up, so an outside driver may share the line
   for (genvar p = 0; p < NPINS; p++) begin : g_pin_drive
      assign drv_on[p] = drive_en[p] && !(st_q.odrain[p] && out_data[p]);
      assign pin_out[p] = out_data[p] && !st_q.odrain[p];
      assign pin_oe_n[p] = !drv_on[p];
   end

   // bus side
   a_ack_follows: assert property (@(posedge clk) disable iff (!reset_n)
      req |=> wb_ack_o)
      else $error("request not answered in the next cycle");

   a_ack_pulse: assert property (@(posedge clk) disable iff (!reset_n)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack stood longer than one cycle");

   a_ack_needs_req: assert property (@(posedge clk) disable iff (!reset_n)
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");

   a_dat_idle: assert property (@(posedge clk) disable iff (!reset_n)
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside the ack cycle");

   a_unmapped_read: assert property (@(posedge clk) disable iff (!reset_n)
      rd && !(hit_imask || hit_change || hit_odstat) |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read returned data");

   a_wr_once: assert property (@(posedge clk) disable iff (!reset_n)
      wr |=> !wr)
      else $error("one write landed twice");

   a_rd_once: assert property (@(posedge clk) disable iff (!reset_n)
      rd |=> !rd)
      else $error("one read taken twice");

   // interrupt mask
   a_mask_hold: assert property (@(posedge clk) disable iff (!reset_n)
      !($past(wr) && ($past(wb_adr_i) == PCIO_OFS_IRQ_ENABLE_SET ||
        $past(wb_adr_i) == PCIO_OFS_IRQ_ENABLE_CLEAR)) |-> $stable(st_q.mask))
      else $error("mask changed without enable or disable write");

   a_mask_set: assert property (@(posedge clk) disable iff (!reset_n)
      wr_ien |=> (st_q.mask & $past(wbits)) == $past(wbits))
      else $error("enable write did not set mask");

   a_mask_keep_set: assert property (@(posedge clk) disable iff (!reset_n)
      wr_ien |=> (st_q.mask & ~$past(wbits)) == ($past(st_q.mask) & ~$past(wbits)))
      else $error("enable write touched a zero bit");

   a_mask_clear: assert property (@(posedge clk) disable iff (!reset_n)
      wr_idis |=> (st_q.mask & $past(wbits)) == '0)
      else $error("disable write did not clear mask");

   a_mask_keep_clear: assert property (@(posedge clk) disable iff (!reset_n)
      wr_idis |=> (st_q.mask & ~$past(wbits)) == ($past(st_q.mask) & ~$past(wbits)))
      else $error("disable write touched a zero bit");

   a_mask_read: assert property (@(posedge clk) disable iff (!reset_n)
      rd && hit_imask |=> wb_dat_o == 32'($past(st_q.mask)))
      else $error("mask read wrong");

   // change detection
   a_sync_chain: assert property (@(posedge clk) disable iff (!reset_n)
      st_q.sync2 == $past(st_q.sync1) && st_q.sync3 == $past(st_q.sync2))
      else $error("pin synchroniser skipped a stage");

   a_no_early_edge: assert property (@(posedge clk) disable iff (!reset_n)
      !primed |-> edge_seen == '0)
      else $error("change reported before the chain filled");

   a_change_edge: assert property (@(posedge clk) disable iff (!reset_n)
      |edge_seen |=> (st_q.change & $past(edge_seen)) == $past(edge_seen))
      else $error("edge not recorded");

   a_change_sticky: assert property (@(posedge clk) disable iff (!reset_n)
      !rd_change |=>
      (st_q.change & $past(st_q.change)) == $past(st_q.change))
      else $error("change bit lost without read");

   a_read_clear: assert property (@(posedge clk) disable iff (!reset_n)
      rd_change |=>
      st_q.change == $past(edge_seen) && wb_dat_o == 32'($past(st_q.change)))
      else $error("status read did not return and clear");

   a_change_clr_read: assert property (@(posedge clk) disable iff (!reset_n)
      (~st_q.change & $past(st_q.change)) != '0 |-> $past(rd_change))
      else $error("change bit cleared without a read");

   a_irq_level: assert property (@(posedge clk) disable iff (!reset_n)
      irq == |(st_q.change & st_q.mask))
      else $error("irq does not follow masked change bits");

   // open drain
   a_od_set: assert property (@(posedge clk) disable iff (!reset_n)
      wr_odset |=> (st_q.odrain & $past(wbits)) == $past(wbits))
      else $error("open drain set failed");

   a_od_keep_set: assert property (@(posedge clk) disable iff (!reset_n)
      wr_odset |=> (st_q.odrain & ~$past(wbits)) == ($past(st_q.odrain) & ~$past(wbits)))
      else $error("open drain set touched a zero bit");

   a_od_clear: assert property (@(posedge clk) disable iff (!reset_n)
      wr_odclr |=> (st_q.odrain & $past(wbits)) == '0)
      else $error("open drain clear failed");

   a_od_keep_clear: assert property (@(posedge clk) disable iff (!reset_n)
      wr_odclr |=> (st_q.odrain & ~$past(wbits)) == ($past(st_q.odrain) & ~$past(wbits)))
      else $error("open drain clear touched a zero bit");

   a_od_hold: assert property (@(posedge clk) disable iff (!reset_n)
      !$past(wr_odset || wr_odclr) |-> $stable(st_q.odrain))
      else $error("open drain changed without a write");

   a_od_read: assert property (@(posedge clk) disable iff (!reset_n)
      rd && hit_odstat |=> wb_dat_o == 32'($past(st_q.odrain)))
      else $error("open drain read wrong");

   a_od_release: assert property (@(posedge clk) disable iff (!reset_n)
      ((st_q.odrain & out_data) & ~pin_oe_n) == '0)
      else $error("open drain drove a one");

   a_od_pushpull: assert property (@(posedge clk) disable iff (!reset_n)
      ((drive_en & ~st_q.odrain) & (pin_oe_n | (pin_out ^ out_data))) == '0)
      else $error("push-pull line not driven with its data");

   a_od_zero_drive: assert property (@(posedge clk) disable iff (!reset_n)
      ((drive_en & st_q.odrain & ~out_data) & (pin_oe_n | pin_out)) == '0)
      else $error("open drain did not pull a zero");

   a_no_drive_off: assert property (@(posedge clk) disable iff (!reset_n)
      (~drive_en & ~pin_oe_n) == '0)
      else $error("line driven without a drive request");
endmodule : pcio_core

//--- shared/pcio_pkg.sv
// package: register map and reset values of the pin change and open-drain block
package pcio_pkg;
   localparam int PCIO_NPINS = 32;
   localparam logic [7:0] PCIO_OFS_IRQ_ENABLE_SET = 8'h40;
   localparam logic [7:0] PCIO_OFS_IRQ_ENABLE_CLEAR = 8'h44;
   localparam logic [7:0] PCIO_OFS_IRQ_MASK_STATUS = 8'h48;
   localparam logic [7:0] PCIO_OFS_PIN_CHANGE_STATUS = 8'h4C;
   localparam logic [7:0] PCIO_OFS_OPEN_DRAIN_SET = 8'h50;
   localparam logic [7:0] PCIO_OFS_OPEN_DRAIN_CLEAR = 8'h54;
   localparam logic [7:0] PCIO_OFS_OPEN_DRAIN_STATUS = 8'h58;
   localparam logic [31:0] PCIO_RST_MASK = 32'h0000_0000;
   localparam logic [31:0] PCIO_RST_CHANGE = 32'h0000_0000;
   localparam logic [31:0] PCIO_RST_OPEN_DRAIN = 32'h0000_0000;
   localparam logic [1:0] PCIO_SYNC_FILL = 2'h3;
endpackage : pcio_pkg

//--- testbench/pcio_core_bench.sv
// self-checking bench for the pin change and open-drain block
`timescale 1ns/1ns
module pcio_core_bench;
   import pcio_pkg::*;
   logic clk = 0, reset_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, irq;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, pin_in, pin_out, pin_oe_n, r;
   logic [31:0] out_data = 32'h0, drive_en = 32'h0, ext_low = 32'h0;
   int n_fail = 0, tests_run = 0;
   pcio_core dut (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_in, .out_data, .drive_en, .pin_out, .pin_oe_n, .irq);
   pcio_pin_model partner (.pin_out, .pin_oe_n, .ext_low, .pin_in);
   always #25 clk = ~clk;
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // called just after a rising edge; the request stands until ack is sampled
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
      do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
      r = wb_dat_o;
      if (n >= 20) begin
         n_fail++;
         finish_test;
      end
      wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask : wb
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(r, e);
   endtask : rd_chk
   task automatic t_reset;
      rd_chk(8'h48, 32'h0);
      rd_chk(8'h58, 32'h0);
      rd_chk(8'h10, 32'h0);
      repeat (8) @(posedge clk);
      rd_chk(8'h4C, 32'h0);
      rd_chk(8'h4C, 32'h0);
      $display("reset test done");
   endtask : t_reset
   task automatic t_mask;
      wb(1'b1, 8'h40, 32'h0000_00F0);
      wb(1'b1, 8'h44, 32'h0000_0030);
      wb(1'b1, 8'h48, 32'hFFFF_FFFF);
      rd_chk(8'h48, 32'h0000_00C0);
      // only the selected byte lane of a write takes effect
      wb_sel_i <= 4'h2;
      wb(1'b1, 8'h40, 32'hFFFF_FFFF);
      wb_sel_i <= 4'hF;
      rd_chk(8'h48, 32'h0000_FFC0);
      $display("mask test done");
   endtask : t_mask
   // a second reset in mid-run clears the mask view and starts no false change
   task automatic t_rst2;
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd_chk(8'h48, 32'h0);
      repeat (8) @(posedge clk);
      rd_chk(8'h4C, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wb(1'b1, 8'h40, 32'h0000_00C0);
      $display("second reset test done");
   endtask : t_rst2
   task automatic t_change;
      ext_low <= 32'h40;
      repeat (8) @(posedge clk);
      ext_low <= 32'h0;
      repeat (8) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rd_chk(8'h4C, 32'h40);
      chk({31'h0, irq}, 32'h0);
      rd_chk(8'h4C, 32'h0);
      // pin 7 driven low by its own output, pin 5 interrupt disabled in the mask but still recorded
      ext_low <= 32'h20; drive_en <= 32'h80;
      repeat (8) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rd_chk(8'h4C, 32'hA0);
      ext_low <= 32'h0; drive_en <= 32'h0;
      repeat (8) @(posedge clk);
      $display("change test done");
   endtask : t_change
   task automatic t_drain;
      drive_en <= 32'h1; out_data <= 32'h1;
      wb(1'b1, 8'h50, 32'h1);
      rd_chk(8'h58, 32'h1);
      chk(pin_oe_n & 32'h1, 32'h1);
      out_data <= 32'h0;
      @(negedge clk);
      chk(pin_oe_n & 32'h1, 32'h0);
      chk(pin_out & 32'h1, 32'h0);
      @(posedge clk);
      wb(1'b1, 8'h54, 32'h2);
      rd_chk(8'h58, 32'h1);
      wb(1'b1, 8'h54, 32'h1);
      rd_chk(8'h58, 32'h0);
      out_data <= 32'h1;
      @(negedge clk);
      chk(pin_oe_n & 32'h1, 32'h0);
      chk(pin_out & 32'h1, 32'h1);
      @(posedge clk);
      $display("open drain test done");
   endtask : t_drain
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_mask;
      t_change;
      t_rst2;
      t_drain;
      finish_test;
   end
   // the whole run needs about 140 cycles; this allows 4000
   initial begin
      #200000;
      n_fail++;
      finish_test;
   end
endmodule : pcio_core_bench

//--- testbench/pcio_pin_model.sv
// pin-side model: pull-up lines that the block or an outside open-drain driver may pull
`timescale 1ns/1ns
module pcio_pin_model (
   // driver side of the block
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe_n,
   // outside drivers that pull a line low, commanded by the bench
   input wire logic [31:0] ext_low,
   // level seen on the lines
   output logic [31:0] pin_in
);
   // a released line with no outside driver floats up to the pull-up level
   assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ~ext_low);
endmodule : pcio_pin_model
